// ===== hdl/fsp_host.sv
// Purpose: Host controller that drives a parallel NOR flash, polls its status and programs its lock word
// Assumes: APB command port; flash pins asynchronous, data inputs passed through two flip-flops
// Notes: One bus cycle per command; software sequences multi-cycle commands
`timescale 1ns/1ns
`default_nettype none
`include "fsp_map.svh"
module fsp_host
	import fsp_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic [22:0] flashAddr,
	output logic [15:0] flashDqOut,
	output logic flashDqOe,
	input wire logic [15:0] flashDqIn,
	output logic flashCe_b,
	output logic flashOe_b,
	output logic flashWe_b,
	input wire logic readyBusyIn
);
	fsp_regs_t r, next_r;
	logic [15:0] dqMeta, dqSync;
	logic rbMeta, rbSync;

	// Pins are asynchronous to clk
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			dqMeta <= 16'h0000;
			dqSync <= 16'h0000;
			rbMeta <= 1'b1;
			rbSync <= 1'b1;
		end else begin
			dqMeta <= flashDqIn;
			dqSync <= dqMeta;
			rbMeta <= readyBusyIn;
			rbSync <= rbMeta;
		end
	end

	// Lock word as sent: reserved bits forced high
	function automatic logic [15:0] lockWord(input logic [15:0] req);
		lockWord = req | `FSP_LOCK_RSVD_MASK;
	endfunction

	// A request that would clear both mode bits is refused
	function automatic logic lockLegal(input logic [15:0] req);
		lockLegal = req[`FSP_LOCK_PWD] | req[`FSP_LOCK_NVM];
	endfunction

	logic apbWr, apbRd, cmdStart, lockOk, forcedReset;
	always_comb begin
		next_r = r;
		next_r.pready = 1'b0;
		// Writes land on the edge that completes the transfer
		apbWr = psel & penable & pwrite & r.pready;
		apbRd = psel & penable & ~pwrite & ~r.pready;
		// Legality judged on the word software loaded, not on the command code
		lockOk = lockLegal(r.wdata);
		cmdStart = apbWr && paddr == `FSP_OFF_CTRL && r.state == FSP_IDLE;
		// After a failure, the next command other than a read or poll is replaced by the reset command
		forcedReset = r.needReset && pwdata[2:0] != `FSP_OP_READ && pwdata[2:0] != `FSP_OP_POLL;
		if (psel & penable & ~r.pready) begin
			next_r.pready = 1'b1;
			next_r.prdata = 32'h0000_0000;
		end
		if (apbWr) begin
			unique case (paddr)
				`FSP_OFF_ADDR: next_r.addr = pwdata[22:0];
				`FSP_OFF_WDATA: next_r.wdata = pwdata[15:0];
				default: ;
			endcase
		end
		if (apbRd) begin
			unique case (paddr)
				`FSP_OFF_STAT: next_r.prdata = {24'h00_0000, r.protValid, r.protectedBlk, r.needReset,
					r.pollDone, r.abort, r.fail, r.busy, rbSync};
				`FSP_OFF_RDATA: next_r.prdata = {16'h0000, r.rdata};
				`FSP_OFF_ADDR: next_r.prdata = {9'h000, r.addr};
				`FSP_OFF_WDATA: next_r.prdata = {16'h0000, r.wdata};
				default: next_r.prdata = 32'h0000_0000;
			endcase
		end
		// A pending reset goes out even when the request itself is refused
		if (cmdStart && (forcedReset || pwdata[2:0] != `FSP_OP_LOCKPGM || lockOk)) begin
			next_r.op = pwdata[2:0];
			next_r.busy = 1'b1;
			next_r.cnt = `FSP_STROBE_CYC;
			// Polls go to the address software loaded: the programmed word or the erasing block
			next_r.bus.addr = r.addr;
			next_r.bus.ceB = 1'b0;
			if (forcedReset) begin
				next_r.op = `FSP_OP_WRITE;
				next_r.bus.dOut = `FSP_RESET_CMD;
				next_r.needReset = 1'b0;
				next_r.state = FSP_WR;
				next_r.bus.weB = 1'b0;
				next_r.bus.dOe = 1'b1;
			end else if (pwdata[2:0] == `FSP_OP_WRITE || pwdata[2:0] == `FSP_OP_LOCKPGM) begin
				next_r.bus.dOut = (pwdata[2:0] == `FSP_OP_LOCKPGM) ? lockWord(r.wdata) : r.wdata;
				next_r.state = FSP_WR;
				next_r.bus.weB = 1'b0;
				next_r.bus.dOe = 1'b1;
			end else begin
				next_r.state = FSP_RD;
				next_r.bus.oeB = 1'b0;
			end
		end
		if (r.state != FSP_IDLE || !cmdStart) begin
			unique case (r.state)
				FSP_IDLE: ;
				FSP_WR: begin
					next_r.cnt = 4'(r.cnt - 4'h1);
					if (r.cnt == 4'h1) begin
						next_r.bus.weB = 1'b1;
						next_r.state = FSP_RECOV;
					end
				end
				FSP_RD: begin
					next_r.cnt = 4'(r.cnt - 4'h1);
					if (r.cnt == 4'h1) begin
						next_r.bus.oeB = 1'b1;
						next_r.rdata = dqSync;
						next_r.state = FSP_DONE;
					end
				end
				FSP_RECOV: begin
					next_r.bus.dOe = 1'b0;
					next_r.bus.ceB = 1'b1;
					next_r.state = FSP_GAP;
				end
				FSP_DONE: begin
					next_r.bus.ceB = 1'b1;
					if (r.op == `FSP_OP_POLL) begin
						// Only bits 7, 6, 5 and 1 are judged; others vary per operation
						next_r.lastPoll = r.rdata;
						// Done when bit 6 stops toggling and bit 7 equals the expected data
						next_r.pollDone = r.rdata[`FSP_BIT_TOGGLE] == r.lastPoll[`FSP_BIT_TOGGLE] &&
							r.rdata[`FSP_BIT_POLL] == r.wdata[`FSP_BIT_POLL];
						// Bit 5 sets the failure flag and bit 1 the abort flag; either one needs a reset
						next_r.fail = r.rdata[`FSP_BIT_ERROR];
						next_r.abort = r.rdata[`FSP_BIT_ABORT];
						if (r.rdata[`FSP_BIT_ERROR] | r.rdata[`FSP_BIT_ABORT]) begin
							next_r.needReset = 1'b1;
						end
					end
					if (r.op == `FSP_OP_PROTRD) begin
						next_r.protectedBlk = r.rdata == `FSP_PROT_YES;
						next_r.protValid = r.rdata == `FSP_PROT_YES || r.rdata == `FSP_PROT_NO;
					end
					next_r.state = FSP_GAP;
				end
				FSP_GAP: begin
					next_r.busy = 1'b0;
					next_r.state = FSP_IDLE;
				end
				default: next_r.state = FSP_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			r <= '{state: FSP_IDLE, bus: '{addr: 23'h00_0000, dOut: 16'h0000, dOe: 1'b0, ceB: 1'b1,
				oeB: 1'b1, weB: 1'b1}, cnt: 4'h0, op: 3'h0, addr: 23'h00_0000, wdata: 16'h0000,
				rdata: 16'h0000, lastPoll: 16'h0000, busy: 1'b0, fail: 1'b0, abort: 1'b0,
				needReset: 1'b0, pollDone: 1'b0, protectedBlk: 1'b0, protValid: 1'b0,
				prdata: 32'h0000_0000, pready: 1'b0};
		end else begin
			r <= next_r;
		end
	end

	assign prdata = r.prdata;
	assign pready = r.pready;
	assign pslverr = 1'b0;
	assign flashAddr = r.bus.addr;
	assign flashDqOut = r.bus.dOut;
	assign flashDqOe = r.bus.dOe;
	assign flashCe_b = r.bus.ceB;
	assign flashOe_b = r.bus.oeB;
	assign flashWe_b = r.bus.weB;

	reset_after_fail_a: assert property (@(posedge clk) disable iff (!rst_b)
		(r.needReset && cmdStart && forcedReset) |=> r.bus.dOut == `FSP_RESET_CMD)
		else $error("command issued after failure without reset");
	reserved_kept_a: assert property (@(posedge clk) disable iff (!rst_b)
		(r.state == FSP_WR && r.op == `FSP_OP_LOCKPGM) |-> (r.bus.dOut & `FSP_LOCK_RSVD_MASK) == `FSP_LOCK_RSVD_MASK)
		else $error("reserved lock bits not high");
	mode_bits_a: assert property (@(posedge clk) disable iff (!rst_b)
		(r.state == FSP_WR && r.op == `FSP_OP_LOCKPGM) |-> (r.bus.dOut[`FSP_LOCK_PWD] | r.bus.dOut[`FSP_LOCK_NVM]))
		else $error("both mode lock bits low");
	fail_flag_a: assert property (@(posedge clk) disable iff (!rst_b)
		(r.state == FSP_DONE && r.op == `FSP_OP_POLL && r.rdata[`FSP_BIT_ERROR]) |=> r.fail && r.needReset)
		else $error("error bit not reported");
	prot_code_a: assert property (@(posedge clk) disable iff (!rst_b)
		(r.state == FSP_DONE && r.op == `FSP_OP_PROTRD) |=> r.protectedBlk == ($past(r.rdata) == `FSP_PROT_YES))
		else $error("protection code misread");
	strobe_len_a: assert property (@(posedge clk) disable iff (!rst_b)
		$fell(r.bus.weB) |-> !r.bus.weB [*4])
		else $error("write strobe too short");
	poll_toggle_a: assert property (@(posedge clk) disable iff (!rst_b)
		(r.state == FSP_DONE && r.op == `FSP_OP_POLL &&
		r.rdata[`FSP_BIT_TOGGLE] != r.lastPoll[`FSP_BIT_TOGGLE]) |=> !r.pollDone)
		else $error("toggling poll taken as done");
	busy_ends_a: assert property (@(posedge clk) disable iff (!rst_b)
		$rose(r.busy) |-> ##[1:12] !r.busy)
		else $error("bus cycle did not end");

	// Pin walks of one strobe; the flash latches data on the rising write strobe
	sequence seqWrLow;
		(!r.bus.weB && !r.bus.ceB && r.bus.dOe && r.bus.oeB) [*7];
	endsequence
	sequence seqWrRelease;
		(r.bus.weB && r.bus.dOe && !r.bus.ceB) ##1 (!r.bus.dOe && r.bus.ceB);
	endsequence
	sequence seqRdLow;
		(!r.bus.oeB && !r.bus.ceB && r.bus.weB && !r.bus.dOe) [*7];
	endsequence
	sequence seqRdRelease;
		(r.bus.oeB && !r.bus.ceB) ##1 r.bus.ceB;
	endsequence
	sequence seqPollEnd;
		r.state == FSP_DONE && r.op == `FSP_OP_POLL;
	endsequence

	wr_walk_a: assert property (@(posedge clk) disable iff (!rst_b)
		$fell(r.bus.weB) |-> seqWrLow ##1 seqWrRelease)
		else $error("write strobe walk broken");
	rd_walk_a: assert property (@(posedge clk) disable iff (!rst_b)
		$fell(r.bus.oeB) |-> seqRdLow ##1 seqRdRelease)
		else $error("read strobe walk broken");
	idle_pins_a: assert property (@(posedge clk) disable iff (!rst_b)
		r.state == FSP_IDLE |-> r.bus.weB && r.bus.oeB && r.bus.ceB && !r.bus.dOe)
		else $error("flash pins active while idle");
	// Bus answer: exactly one wait state, one cycle of ready
	pready_pulse_a: assert property (@(posedge clk) disable iff (!rst_b)
		r.pready |=> !r.pready)
		else $error("ready held over two cycles");
	pready_answer_a: assert property (@(posedge clk) disable iff (!rst_b)
		(psel && penable && !r.pready) |=> r.pready)
		else $error("access phase not answered");
	busy_refuse_a: assert property (@(posedge clk) disable iff (!rst_b)
		(apbWr && paddr == `FSP_OFF_CTRL && r.state != FSP_IDLE) |=> $stable(r.op) && $stable(r.bus.addr))
		else $error("command taken while busy");
	cmd_addr_a: assert property (@(posedge clk) disable iff (!rst_b)
		$rose(r.busy) |-> r.bus.addr == r.addr)
		else $error("flash address differs from loaded address");
	need_clear_a: assert property (@(posedge clk) disable iff (!rst_b)
		(cmdStart && forcedReset) |=> !r.needReset && r.state == FSP_WR)
		else $error("forced reset not issued");
	write_data_a: assert property (@(posedge clk) disable iff (!rst_b)
		(cmdStart && pwdata[2:0] == `FSP_OP_WRITE && !forcedReset) |=> r.bus.dOut == $past(r.wdata))
		else $error("write data not driven");
	lock_refused_a: assert property (@(posedge clk) disable iff (!rst_b)
		(cmdStart && pwdata[2:0] == `FSP_OP_LOCKPGM && !lockOk && !forcedReset) |=> r.state == FSP_IDLE && !r.busy)
		else $error("illegal lock word sent");

	// Poll verdicts: history, flags and completion; protection code validity; read data hold
	abort_flag_a: assert property (@(posedge clk) disable iff (!rst_b)
		seqPollEnd ##0 r.rdata[`FSP_BIT_ABORT] |=> r.abort && r.needReset)
		else $error("abort bit not reported");
	fail_clear_a: assert property (@(posedge clk) disable iff (!rst_b)
		seqPollEnd ##0 !r.rdata[`FSP_BIT_ERROR] |=> !r.fail)
		else $error("failure reported without error bit");
	poll_steady_a: assert property (@(posedge clk) disable iff (!rst_b)
		seqPollEnd ##0 (r.rdata[`FSP_BIT_TOGGLE] == r.lastPoll[`FSP_BIT_TOGGLE] &&
		r.rdata[`FSP_BIT_POLL] == r.wdata[`FSP_BIT_POLL]) |=> r.pollDone)
		else $error("settled poll not taken as done");
	history_kept_a: assert property (@(posedge clk) disable iff (!rst_b)
		seqPollEnd |=> r.lastPoll == $past(r.rdata))
		else $error("poll history not kept");
	prot_valid_a: assert property (@(posedge clk) disable iff (!rst_b)
		(r.state == FSP_DONE && r.op == `FSP_OP_PROTRD) |=>
		r.protValid == ($past(r.rdata) == `FSP_PROT_YES || $past(r.rdata) == `FSP_PROT_NO))
		else $error("protection code validity wrong");
	rdata_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
		r.state != FSP_RD |=> $stable(r.rdata))
		else $error("read data changed outside a read");
endmodule
`default_nettype wire

// ===== hdl/fsp_map.svh
// Purpose: Offsets, fields, codes and timing counts of the flash status and lock controller
// Assumes: 32-bit APB data, one aligned word per register
// Notes: Host side; the flash itself is outside
`ifndef FSP_MAP_SVH
`define FSP_MAP_SVH
`define FSP_OFF_CTRL 12'h000
`define FSP_OFF_ADDR 12'h004
`define FSP_OFF_WDATA 12'h008
`define FSP_OFF_STAT 12'h00C
`define FSP_OFF_RDATA 12'h010
`define FSP_OFF_LOCK 12'h014
`define FSP_OP_READ 3'h0
`define FSP_OP_WRITE 3'h1
`define FSP_OP_POLL 3'h2
`define FSP_OP_LOCKPGM 3'h3
`define FSP_OP_PROTRD 3'h4
`define FSP_BIT_POLL 7
`define FSP_BIT_TOGGLE 6
`define FSP_BIT_ERROR 5
`define FSP_BIT_ETIMER 3
`define FSP_BIT_ALTTOG 2
`define FSP_BIT_ABORT 1
`define FSP_LOCK_RSVD_MASK 16'hFFE8
`define FSP_LOCK_BOOT 4
`define FSP_LOCK_PWD 2
`define FSP_LOCK_NVM 1
`define FSP_LOCK_EXT 0
`define FSP_PROT_YES 16'h0001
`define FSP_PROT_NO 16'h0000
`define FSP_RESET_CMD 16'h00F0
`define FSP_STROBE_NS 70
`define FSP_CLK_NS 10
`define FSP_STROBE_CYC 4'((`FSP_STROBE_NS + `FSP_CLK_NS - 1) / `FSP_CLK_NS)
`endif

// ===== hdl/fsp_pkg.sv
// Purpose: Types of the flash status and lock controller
// Assumes: Included map header holds all numbers
// Notes: None
package fsp_pkg;
	typedef enum logic [5:0] {
		FSP_IDLE = 6'b00_0001,
		FSP_WR = 6'b00_0010,
		FSP_RD = 6'b00_0100,
		FSP_RECOV = 6'b00_1000,
		FSP_DONE = 6'b01_0000,
		FSP_GAP = 6'b10_0000
	} fsp_state_t;
	typedef struct packed {
		logic [22:0] addr;
		logic [15:0] dOut;
		logic dOe;
		logic ceB;
		logic oeB;
		logic weB;
	} fsp_bus_t;
	typedef struct packed {
		fsp_state_t state;
		fsp_bus_t bus;
		logic [3:0] cnt;
		logic [2:0] op;
		logic [22:0] addr;
		logic [15:0] wdata;
		logic [15:0] rdata;
		logic [15:0] lastPoll;
		logic busy;
		logic fail;
		logic abort;
		logic needReset;
		logic pollDone;
		logic protectedBlk;
		logic protValid;
		logic [31:0] prdata;
		logic pready;
	} fsp_regs_t;
endpackage

// ===== verif/fsp_flash_model.sv
// Purpose: Behavioural flash on the far side of the host controller
// Assumes: Bench picks the status shown through mode
// Notes: Released data lines show the inverse of the last value
`timescale 1ns/1ns
`default_nettype none
module fsp_flash_model import fsp_pkg::*; (
	input wire logic [22:0] addr,
	input wire logic [15:0] din,
	input wire logic dinEn,
	input wire logic ceB,
	input wire logic oeB,
	input wire logic weB,
	input wire logic [1:0] mode,
	output logic [15:0] dout,
	output logic readyBusy,
	output logic [15:0] lockWord
);
	logic [15:0] data = 16'h0000;
	logic [15:0] lastOut = 16'h0000;
	logic [15:0] val;
	logic [15:0] nextLock;
	// Starts high so a first status read differs from a cleared host history
	logic tog = 1'b1;
	logic blkProt;
	initial lockWord = 16'hFFFF;
	// Block 0 has its nonvolatile bit programmed, block 1 only its volatile default
	// Global nonvolatile lock held at 0, so neither block's nonvolatile bit can change
	assign blkProt = ~addr[22] | ~lockWord[4];
	assign nextLock = lockWord & din;
	// Open drain with pull-up: released means high
	assign readyBusy = !(mode == 2'h1 || mode == 2'h3);
	always_comb begin
		case (mode)
			2'h0: val = (addr[1:0] == 2'h2) ? {15'h0000, blkProt} : data;
			default: val = {8'h00, ~data[7], tog, mode == 2'h2, 3'h0, mode == 2'h3, 1'b0};
		endcase
	end
	assign dout = (!ceB && !oeB) ? val : ~lastOut;
	// Strobe edges count only while selected; the release at reset is no cycle
	always @(posedge oeB) begin
		if (!ceB) begin
			lastOut <= val;
			// Only a running operation toggles; array reads leave it still
			if (mode != 2'h0) tog <= ~tog;
		end
	end
	always @(posedge weB) begin
		if (!ceB) begin
			if (addr == 23'h00_0040) begin
				if (nextLock[2] | nextLock[1]) lockWord <= nextLock;
			end else data <= dinEn ? din : 16'hFFFF;
		end
	end
endmodule
`default_nettype wire

// ===== verif/fsp_host_bench.sv
// Purpose: Self-checking bench of the flash host controller
// Assumes: Flash model answers on the pins
// Notes: Table rows first, then awkward cases and reset
`timescale 1ns/1ns
`default_nettype none
`include "fsp_map.svh"
module fsp_host_bench import fsp_pkg::*;;
	typedef struct packed {
		logic [1:0] mode;
		logic [2:0] op;
		logic [22:0] addr;
		logic [15:0] wd;
		logic [7:0] mask;
		logic [7:0] stat;
		logic [15:0] lock;
	} fsp_row_t;
	logic clk = 1'b0, rstB = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic pready, ceB, oeB, weB, rb, dqOe;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, prdata, q;
	logic [22:0] fAddr;
	logic [15:0] dqOut, dqIn, lockWord;
	logic [1:0] mode = 2'h0;
	int nErrors = 0, numChecks = 0, cyc = 0;
	// Lock writes go to 40h, protection reads to offset 2 of a block
	fsp_row_t rows [10] = '{
		'{2'h0, 3'h4, 23'h40_0002, 16'h0000, 8'hC0, 8'h80, 16'hFFFF},
		'{2'h0, 3'h3, 23'h00_0040, 16'h0016, 8'h00, 8'h00, 16'hFFFE},
		'{2'h0, 3'h3, 23'h00_0040, 16'h0004, 8'h00, 8'h00, 16'hFFEC},
		'{2'h0, 3'h3, 23'h00_0040, 16'h0012, 8'h00, 8'h00, 16'hFFEC},
		'{2'h0, 3'h3, 23'h00_0040, 16'h0017, 8'h00, 8'h00, 16'hFFEC},
		'{2'h0, 3'h4, 23'h40_0002, 16'h0000, 8'hC0, 8'hC0, 16'hFFEC},
		'{2'h0, 3'h4, 23'h00_0002, 16'h0000, 8'hC0, 8'hC0, 16'hFFEC},
		'{2'h1, 3'h2, 23'h00_0010, 16'h0080, 8'h1F, 8'h00, 16'hFFEC},
		'{2'h3, 3'h2, 23'h00_0010, 16'h0080, 8'h0F, 8'h08, 16'hFFEC},
		'{2'h2, 3'h2, 23'h00_0010, 16'h0080, 8'h25, 8'h25, 16'hFFEC}
	};
	always #5 clk = ~clk;
	fsp_host u_dut (.clk(clk), .rst_b(rstB), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(),
		.flashAddr(fAddr), .flashDqOut(dqOut), .flashDqOe(dqOe), .flashDqIn(dqIn),
		.flashCe_b(ceB), .flashOe_b(oeB), .flashWe_b(weB), .readyBusyIn(rb));
	fsp_flash_model u_model (.addr(fAddr), .din(dqOut), .dinEn(dqOe), .ceB(ceB), .oeB(oeB), .weB(weB),
		.mode(mode), .dout(dqIn), .readyBusy(rb), .lockWord(lockWord));
	task automatic printVerdict();
		if (nErrors == 0 && numChecks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		numChecks++;
		if (got !== exp) begin
			nErrors++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask
	// Entered just after a rising edge; holds the request until pready
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		r = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic runOp(input logic [2:0] op, input logic [22:0] a, input logic [15:0] wd);
		apb(1'b1, `FSP_OFF_ADDR, {9'h000, a}, q);
		apb(1'b1, `FSP_OFF_WDATA, {16'h0000, wd}, q);
		apb(1'b1, `FSP_OFF_CTRL, {29'h0000_0000, op}, q);
		do apb(1'b0, `FSP_OFF_STAT, 32'h0000_0000, q); while (q[1] !== 1'b0);
	endtask
	// Whole run needs a few hundred cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			nErrors++;
			printVerdict();
		end
	end
	initial begin
		repeat (6) @(posedge clk);
		rstB <= 1'b1;
		@(posedge clk);
		foreach (rows[i]) begin
			mode <= rows[i].mode;
			runOp(rows[i].op, rows[i].addr, rows[i].wd);
			chk("stat", {24'h00_0000, rows[i].stat}, q & {24'h00_0000, rows[i].mask});
			chk("lock", {16'h0000, rows[i].lock}, {16'h0000, lockWord});
		end
		mode <= 2'h0;
		runOp(3'h1, 23'h00_0010, 16'h00A5);
		chk("cmd after error", 32'h0000_00F0, {16'h0000, u_model.data});
		runOp(3'h3, 23'h00_0040, 16'h0001);
		chk("lock refused", 32'h0000_FFEC, {16'h0000, lockWord});
		// Bits 5 and 1 clear so the later array poll reads no failure
		runOp(3'h1, 23'h00_0010, 16'h0085);
		runOp(3'h0, 23'h00_0010, 16'h0000);
		apb(1'b0, `FSP_OFF_RDATA, 32'h0000_0000, q);
		chk("rdata", 32'h0000_0085, q);
		runOp(3'h2, 23'h00_0010, 16'h0080);
		runOp(3'h2, 23'h00_0010, 16'h0080);
		chk("poll done", 32'h0000_0010, q & 32'h0000_0030);
		apb(1'b0, 12'h020, 32'h0000_0000, q);
		chk("unmapped", 32'h0000_0000, q);
		rstB <= 1'b0;
		repeat (2) @(posedge clk);
		rstB <= 1'b1;
		@(posedge clk);
		apb(1'b0, `FSP_OFF_STAT, 32'h0000_0000, q);
		chk("stat after reset", 32'h0000_0001, q & 32'h0000_003F);
		printVerdict();
	end
endmodule
`default_nettype wire
